/* File: verilog/swkcfg_pkg.sv */
// Constants shared by the selective-wake payload and tolerance configuration block.
// Assumes a single core clock at the rate given below and 7-bit register addresses.
package swkcfg_pkg;

  // Core clock rate, used to turn filter times into cycle counts.
  localparam int unsigned CORE_CLK_KHZ = 40000;

  // Serial frame layout: 7 address bits, 1 write bit, 16 data bits, 8 check bits.
  localparam int unsigned ADDR_W       = 7;
  localparam int unsigned DATA_W       = 16;
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned HDR_BITS     = 8;
  localparam int unsigned BODY_END     = 24;

  // Register addresses.
  localparam logic [6:0] ADDR_PAYLOAD_SEVEN_SIX   = 7'h37;
  localparam logic [6:0] ADDR_PAYLOAD_FIVE_FOUR   = 7'h38;
  localparam logic [6:0] ADDR_PAYLOAD_THREE_TWO   = 7'h39;
  localparam logic [6:0] ADDR_PAYLOAD_ONE_ZERO    = 7'h3a;
  localparam logic [6:0] ADDR_FD_TOLERANCE_CONFIG = 7'h3b;

  // Reset values after power-on or soft reset.
  localparam logic [15:0] PAYLOAD_RESET = 16'h0000;
  localparam logic [15:0] FD_CFG_RESET  = 16'h0000;

  // Field positions within the tolerance configuration register.
  localparam int unsigned FD_ON_BIT        = 0;
  localparam int unsigned GLITCH_LSB       = 1;
  localparam int unsigned GLITCH_MSB       = 3;
  localparam int unsigned ERR_OFF_BIT      = 5;
  localparam logic [15:0] FD_CFG_WMASK     = 16'h002f;

  // Dominant filter times per code, in ns, and the cycles they take.
  localparam int unsigned GLITCH_NS [8] = '{50, 100, 150, 200, 250, 300, 350, 775};
  localparam int unsigned GLITCH_CYC_W  = 5;

  function automatic logic [4:0] glitch_cycles(input logic [2:0] code);
    int unsigned cyc;
    cyc = (GLITCH_NS[code] * (CORE_CLK_KHZ / 1000) + 999) / 1000;
    if (cyc < 1)
      cyc = 1;
    return cyc[4:0];
  endfunction

  // Serial port frame states, Gray coded along the usual path.
  typedef enum logic [1:0] {
    SWKCFG_IDLE = 2'b00,
    SWKCFG_HDR  = 2'b01,
    SWKCFG_BODY = 2'b11,
    SWKCFG_TAIL = 2'b10
  } swkcfg_state_t;

endpackage

/* File: verilog/swkcfg_sync.sv */
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes the inputs change slowly compared with the core clock.
`timescale 1ns/1ps
module swkcfg_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             nrst,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_r;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      meta_r   <= INIT;
      sync_out <= INIT;
    end
    else
    begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

/* File: verilog/swkcfg_top.sv */
// Selective-wake payload and tolerance configuration registers with serial access.
// Assumes a serial host (clock idle low, sampled on rising edges) far slower than core_clk.
//
// Overview of operation
// R01 - 0x37 holds payload bytes seven and six
// R02 - 0x38 holds payload bytes five and four
// R03 - 0x39 holds payload bytes three and two
// R04 - 0x3a holds payload bytes one and zero
// R05 - Power-on or soft reset clears all registers
// R06 - Restart keeps payload registers unchanged
// R07 - Restart zeroes reserved config bits, keeps fields
// R08 - Config bit 0 enables tolerant mode
// R09 - Bits 3:1 choose dominant filter time
// R10 - Config bit 5 disables error counter
// R11 - Counter disable only while tolerant mode on
// R12 - Silence timeout clears counter disable bit
// R13 - Host selects normal receiver above 2 Mbit/s
// R14 - Reserved config bits ignore writes, read zero
// R15 - Length codes must match before payload compare
// R16 - Device clear beats same-cycle software write
`timescale 1ns/1ps
module swkcfg_top
  import swkcfg_pkg::*;
(
  // Clock and reset
  input  wire logic                           core_clk,
  input  wire logic                           nrst,
  // Serial register port
  input  wire logic                           spi_csn,
  input  wire logic                           spi_sclk,
  input  wire logic                           spi_mosi,
  output logic                                spi_miso_o,
  output logic                                spi_miso_oe,
  // Device events
  input  wire logic                           soft_rst,
  input  wire logic                           restart,
  input  wire logic                           silence_timeout,
  // Received frame to compare
  input  wire logic                           rx_frame_valid,
  input  wire logic [3:0]                     rx_length_code,
  input  wire logic [3:0]                     cfg_length_code,
  input  wire logic [63:0]                    rx_payload,
  output logic                                payload_match,
  // Configuration to the frame detector
  output logic                                fd_tolerance_on,
  output logic [swkcfg_pkg::GLITCH_CYC_W-1:0] dominant_glitch_cycles,
  output logic                                error_counter_active,
  output logic [63:0]                         expected_payload
);

  // Synchronised serial pins; chip select idles high.
  logic       csn_s;
  logic       sclk_s;
  logic       mosi_s;
  logic       sclk_d_r;
  logic       sclk_rise;
  logic       sclk_fall;

  swkcfg_sync #(
    .WIDTH (3),
    .INIT  (3'b100)
  ) u_pin_sync (
    .core_clk (core_clk),
    .nrst     (nrst),
    .async_in ({spi_csn, spi_sclk, spi_mosi}),
    .sync_out ({csn_s, sclk_s, mosi_s})
  );

  assign sclk_rise = sclk_s & ~sclk_d_r;
  assign sclk_fall = ~sclk_s & sclk_d_r;

  // Serial frame engine.
  swkcfg_state_t     state_r;
  swkcfg_state_t     state_nxt;
  logic [5:0]        bit_cnt_r;
  logic [5:0]        bit_cnt_nxt;
  logic [23:0]       shift_in_r;
  logic [23:0]       shift_in_nxt;
  logic [15:0]       shift_out_r;
  logic [15:0]       shift_out_nxt;
  logic [6:0]        addr_r;
  logic [6:0]        addr_nxt;
  logic              wr_r;
  logic              wr_nxt;
  logic              wr_commit;
  logic [15:0]       wr_data;
  logic [15:0]       rd_data;
  logic [6:0]        hdr_addr;

  // Register storage.
  logic [15:0]       pay_seven_six_r;
  logic [15:0]       pay_five_four_r;
  logic [15:0]       pay_three_two_r;
  logic [15:0]       pay_one_zero_r;
  logic [15:0]       fd_cfg_r;
  logic [15:0]       pay_seven_six_nxt;
  logic [15:0]       pay_five_four_nxt;
  logic [15:0]       pay_three_two_nxt;
  logic [15:0]       pay_one_zero_nxt;
  logic [15:0]       fd_cfg_nxt;

  // Derived outputs.
  logic [4:0]        glitch_nxt;
  logic              match_nxt;
  logic [7:0]        byte_eq;
  logic [3:0]        cmp_len;

  assign hdr_addr = shift_in_r[6:0];

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_data = 16'h0000;
    if (hdr_addr == ADDR_PAYLOAD_SEVEN_SIX)
      rd_data = pay_seven_six_r;
    else if (hdr_addr == ADDR_PAYLOAD_FIVE_FOUR)
      rd_data = pay_five_four_r;
    else if (hdr_addr == ADDR_PAYLOAD_THREE_TWO)
      rd_data = pay_three_two_r;
    else if (hdr_addr == ADDR_PAYLOAD_ONE_ZERO)
      rd_data = pay_one_zero_r;
    else if (hdr_addr == ADDR_FD_TOLERANCE_CONFIG)
      rd_data = fd_cfg_r & FD_CFG_WMASK; // R14
  end

  // A write is committed on the rising edge that completes the data field, so a frame cut
  // short by chip select before that edge never changes a register.
  always_comb
  begin
    state_nxt     = state_r;
    bit_cnt_nxt   = bit_cnt_r;
    shift_in_nxt  = shift_in_r;
    shift_out_nxt = shift_out_r;
    addr_nxt      = addr_r;
    wr_nxt        = wr_r;
    wr_commit     = 1'b0;
    wr_data       = {shift_in_r[14:0], mosi_s};
    if (csn_s)
    begin
      state_nxt   = SWKCFG_IDLE;
      bit_cnt_nxt = 6'd0;
    end
    else
    begin
      case (state_r)
        SWKCFG_IDLE:
        begin
          state_nxt     = SWKCFG_HDR;
          bit_cnt_nxt   = 6'd0;
          shift_out_nxt = 16'h0000;
        end
        SWKCFG_HDR:
        begin
          if (sclk_rise)
          begin
            shift_in_nxt = {shift_in_r[22:0], mosi_s};
            bit_cnt_nxt  = bit_cnt_r + 6'd1;
            if (bit_cnt_r == 6'(HDR_BITS - 1))
            begin
              state_nxt = SWKCFG_BODY;
              addr_nxt  = shift_in_r[6:0];
              wr_nxt    = mosi_s;
            end
          end
          if (state_nxt == SWKCFG_BODY)
            shift_out_nxt = rd_data;
        end
        SWKCFG_BODY:
        begin
          if (sclk_rise)
          begin
            shift_in_nxt = {shift_in_r[22:0], mosi_s};
            bit_cnt_nxt  = bit_cnt_r + 6'd1;
            if (bit_cnt_r == 6'(BODY_END - 1))
            begin
              state_nxt = SWKCFG_TAIL;
              wr_commit = wr_r;
            end
          end
          if (sclk_fall && bit_cnt_r > 6'(HDR_BITS))
            shift_out_nxt = {shift_out_r[14:0], 1'b0};
        end
        SWKCFG_TAIL:
        begin
          if (sclk_fall)
            shift_out_nxt = 16'h0000;
        end
        default:
          state_nxt = SWKCFG_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_r     <= SWKCFG_IDLE;
      bit_cnt_r   <= 6'd0;
      shift_in_r  <= 24'h000000;
      shift_out_r <= 16'h0000;
      addr_r      <= 7'h00;
      wr_r        <= 1'b0;
      sclk_d_r    <= 1'b0;
    end
    else
    begin
      state_r     <= state_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      shift_in_r  <= shift_in_nxt;
      shift_out_r <= shift_out_nxt;
      addr_r      <= addr_nxt;
      wr_r        <= wr_nxt;
      sclk_d_r    <= sclk_s;
    end
  end

  assign spi_miso_o  = shift_out_r[15];
  assign spi_miso_oe = ~csn_s;

  // Register update. Restart re-masks the configuration register and drops a same-cycle write: payload registers keep their value and
  // the configuration register never stores its reserved bits, so they are zero after it.
  always_comb
  begin
    pay_seven_six_nxt = pay_seven_six_r;
    pay_five_four_nxt = pay_five_four_r;
    pay_three_two_nxt = pay_three_two_r;
    pay_one_zero_nxt  = pay_one_zero_r;
    fd_cfg_nxt        = fd_cfg_r;
    if (soft_rst)
    begin
      pay_seven_six_nxt = PAYLOAD_RESET; // R05
      pay_five_four_nxt = PAYLOAD_RESET; // R05
      pay_three_two_nxt = PAYLOAD_RESET; // R05
      pay_one_zero_nxt  = PAYLOAD_RESET; // R05
      fd_cfg_nxt        = FD_CFG_RESET; // R05
    end
    else
    begin
      if (restart)
      begin
        fd_cfg_nxt = fd_cfg_r & FD_CFG_WMASK; // R06 R07
      end
      else if (wr_commit)
      begin
        if (addr_r == ADDR_PAYLOAD_SEVEN_SIX)
          pay_seven_six_nxt = wr_data; // R01
        else if (addr_r == ADDR_PAYLOAD_FIVE_FOUR)
          pay_five_four_nxt = wr_data; // R02
        else if (addr_r == ADDR_PAYLOAD_THREE_TWO)
          pay_three_two_nxt = wr_data; // R03
        else if (addr_r == ADDR_PAYLOAD_ONE_ZERO)
          pay_one_zero_nxt = wr_data; // R04
        else if (addr_r == ADDR_FD_TOLERANCE_CONFIG)
          fd_cfg_nxt = wr_data & FD_CFG_WMASK; // R14
      end
      if (silence_timeout)
        fd_cfg_nxt[ERR_OFF_BIT] = 1'b0; // R12 R16
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pay_seven_six_r <= PAYLOAD_RESET;
      pay_five_four_r <= PAYLOAD_RESET;
      pay_three_two_r <= PAYLOAD_RESET;
      pay_one_zero_r  <= PAYLOAD_RESET;
      fd_cfg_r        <= FD_CFG_RESET;
    end
    else
    begin
      pay_seven_six_r <= pay_seven_six_nxt;
      pay_five_four_r <= pay_five_four_nxt;
      pay_three_two_r <= pay_three_two_nxt;
      pay_one_zero_r  <= pay_one_zero_nxt;
      fd_cfg_r        <= fd_cfg_nxt;
    end
  end

  // Payload compare. Only the first min(length, 8) bytes count; byte zero sits in bits 7:0.
  assign cmp_len = cfg_length_code[3] ? 4'd8 : cfg_length_code;

  always_comb
  begin
    for (int i = 0; i < 8; i++)
      byte_eq[i] = (i >= cmp_len) || (rx_payload[8*i +: 8] == expected_payload[8*i +: 8]);
    match_nxt  = rx_frame_valid && (rx_length_code == cfg_length_code) && (&byte_eq); // R15
    glitch_nxt = glitch_cycles(fd_cfg_r[GLITCH_MSB:GLITCH_LSB]); // R09
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      payload_match          <= 1'b0;
      fd_tolerance_on        <= 1'b0;
      dominant_glitch_cycles <= 5'd0;
      error_counter_active   <= 1'b1;
      expected_payload       <= 64'h0000000000000000;
    end
    else
    begin
      payload_match          <= match_nxt;
      fd_tolerance_on        <= fd_cfg_r[FD_ON_BIT]; // R08
      dominant_glitch_cycles <= glitch_nxt; // R09
      // The disable bit has no effect unless tolerant mode is on.
      error_counter_active   <= ~(fd_cfg_r[ERR_OFF_BIT] & fd_cfg_r[FD_ON_BIT]); // R10 R11
      expected_payload       <= {pay_seven_six_r, pay_five_four_r, pay_three_two_r, pay_one_zero_r};
    end
  end

endmodule

/* File: dv/swkcfg_top_asserts.sv */
// Checker for the selective-wake configuration block, bound to its top ports.
// Assumes the serial host keeps frames apart and fires no restart in mid-frame.
`timescale 1ns/1ps
module swkcfg_top_asserts
  import swkcfg_pkg::*;
(
  // Clock and reset
  input wire logic                           core_clk,
  input wire logic                           nrst,
  // Serial port and events
  input wire logic                           spi_csn,
  input wire logic                           spi_miso_oe,
  input wire logic                           soft_rst,
  input wire logic                           restart,
  input wire logic                           silence_timeout,
  // Compare
  input wire logic                           rx_frame_valid,
  input wire logic [3:0]                     rx_length_code,
  input wire logic [3:0]                     cfg_length_code,
  input wire logic [63:0]                    rx_payload,
  input wire logic                           payload_match,
  // Detector configuration
  input wire logic                           fd_tolerance_on,
  input wire logic [swkcfg_pkg::GLITCH_CYC_W-1:0] dominant_glitch_cycles,
  input wire logic                           error_counter_active,
  input wire logic [63:0]                    expected_payload
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_cleared;
    expected_payload == 64'h0 && !fd_tolerance_on && dominant_glitch_cycles == 5'h02 && error_counter_active;
  endsequence
  sequence s_fields_hold;
    ($stable(expected_payload) && $stable(dominant_glitch_cycles) && $stable(error_counter_active)) [*2];
  endsequence
  property p_soft_clear;
    soft_rst |=> ##1 s_cleared;
  endproperty
  a_soft_clear: assert property (p_soft_clear) else $error("soft reset did not clear");
  property p_restart_keep;
    restart && spi_csn && !soft_rst && !silence_timeout |=> s_fields_hold;
  endproperty
  a_restart_keep: assert property (p_restart_keep) else $error("restart changed settings");
  property p_glitch_code;
    $past(nrst, 2) |-> dominant_glitch_cycles inside {5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h1f};
  endproperty
  a_glitch_code: assert property (p_glitch_code) else $error("filter cycles off table");
  property p_counter_needs_fd;
    !fd_tolerance_on |-> error_counter_active;
  endproperty
  a_counter_needs_fd: assert property (p_counter_needs_fd) else $error("counter off without fd mode");
  property p_silence_clear;
    silence_timeout && !soft_rst |=> ##1 error_counter_active;
  endproperty
  a_silence_clear: assert property (p_silence_clear) else $error("silence did not clear");
  property p_len_mismatch;
    rx_frame_valid && rx_length_code != cfg_length_code |=> !payload_match;
  endproperty
  a_len_mismatch: assert property (p_len_mismatch) else $error("match despite length");
  property p_full_match;
    rx_frame_valid && spi_csn && $stable(expected_payload) && rx_length_code == cfg_length_code && rx_length_code[3]
      && rx_payload == expected_payload |=> payload_match;
  endproperty
  a_full_match: assert property (p_full_match) else $error("equal payload missed");
  property p_match_cause;
    payload_match |-> $past(rx_frame_valid);
  endproperty
  a_match_cause: assert property (p_match_cause) else $error("match without frame");
  property p_miso_release;
    spi_csn [*4] |-> !spi_miso_oe;
  endproperty
  a_miso_release: assert property (p_miso_release) else $error("data out driven while idle");
endmodule
bind swkcfg_top swkcfg_top_asserts u_chk (.core_clk, .nrst, .spi_csn, .spi_miso_oe, .soft_rst, .restart,
  .silence_timeout, .rx_frame_valid, .rx_length_code, .cfg_length_code, .rx_payload, .payload_match,
  .fd_tolerance_on, .dominant_glitch_cycles, .error_counter_active, .expected_payload);

/* File: dv/swkcfg_host.sv */
// Host model: sends 32-bit frames, address and write bit first, MSB first.
// Assumes the device samples on rising serial clock edges.
`timescale 1ns/1ps
module swkcfg_host (
  // Pacing clock
  input  wire logic core_clk,
  // Serial port
  output logic      spi_csn,
  output logic      spi_sclk,
  output logic      spi_mosi,
  input  wire logic spi_miso_o,
  input  wire logic spi_miso_oe
);
  initial
  begin
    spi_csn = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic half();
    repeat (8) @(negedge core_clk);
  endtask
  // A bit taken while the device does not drive reads as the inverse, so a read never passes on a released line.
  task automatic xfer(input logic [6:0] a, input logic w, input logic [15:0] d, output logic [15:0] q);
    logic [31:0] f;
    f = {a, w, d, 8'h00};
    q = 16'h0000;
    @(negedge core_clk);
    spi_csn = 1'b0;
    for (int i = 31; i >= 0; i--)
    begin
      spi_mosi = f[i];
      half();
      spi_sclk = 1'b1;
      if (i <= 23 && i >= 8)
        q = {q[14:0], spi_miso_oe ? spi_miso_o : ~spi_miso_o};
      half();
      spi_sclk = 1'b0;
    end
    spi_mosi = ~spi_mosi;
    spi_csn = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask
endmodule

/* File: dv/tb_swkcfg_top.sv */
// Self-checking bench for the selective-wake configuration block.
// Assumes the host model in swkcfg_host and the bound checker.
`timescale 1ns/1ps
module tb_swkcfg_top;
  import swkcfg_pkg::*;
  logic                    core_clk, nrst, spi_csn, spi_sclk, spi_mosi, spi_miso_o, spi_miso_oe;
  logic                    soft_rst, restart, silence_timeout, rx_frame_valid, payload_match;
  logic                    fd_tolerance_on, error_counter_active;
  logic [3:0]              rx_length_code, cfg_length_code, rl;
  logic [63:0]             rx_payload, expected_payload, pl;
  logic [GLITCH_CYC_W-1:0] dominant_glitch_cycles;
  logic [31:0]             seed = 32'h151712a0;
  logic [15:0]             rd;
  logic [15:0]             v [5];
  logic [15:0]             ec [3] = '{16'h0021, 16'h0020, 16'h0001};
  int                      num_errors = 0;
  int                      total_checks = 0;
  swkcfg_top DUT (.core_clk, .nrst, .spi_csn, .spi_sclk, .spi_mosi, .spi_miso_o, .spi_miso_oe, .soft_rst,
    .restart, .silence_timeout, .rx_frame_valid, .rx_length_code, .cfg_length_code, .rx_payload, .payload_match,
    .fd_tolerance_on, .dominant_glitch_cycles, .error_counter_active, .expected_payload);
  swkcfg_host host (.core_clk, .spi_csn, .spi_sclk, .spi_mosi, .spi_miso_o, .spi_miso_oe);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [63:0] glitch_exp(input int c);
    int ns [8] = '{50, 100, 150, 200, 250, 300, 350, 775};
    return 64'((ns[c] * 40 + 999) / 1000);
  endfunction
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    host.xfer(a, 1'b0, 16'h0000, rd);
    chk("register", 64'(e), 64'(rd));
  endtask
  task automatic cmp(input logic [3:0] l, input logic [63:0] p, input logic e);
    rx_length_code = l;
    rx_payload = p;
    rx_frame_valid = 1'b1;
    cyc(1);
    // The match pulse stands for one cycle only, so it is looked at before the frame strobe drops.
    chk("payload_match", 64'(e), 64'(payload_match));
    rx_frame_valid = 1'b0;
    cyc(1);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial
  begin
    #1500000;
    num_errors++;
    summarize();
  end
  initial
  begin
    {nrst, soft_rst, restart, silence_timeout, rx_frame_valid} = 5'h00;
    {rx_length_code, cfg_length_code, rx_payload} = {8'h08, 64'h0};
    cyc(5);
    nrst = 1'b1;
    cyc(4);
    for (int i = 0; i < 5; i++)
      rdchk(7'h37 + 7'(i), 16'h0000);
    for (int i = 0; i < 5; i++)
    begin
      v[i] = 16'(xs());
      host.xfer(7'h37 + 7'(i), 1'b1, v[i], rd);
    end
    v[4] &= 16'h002f;
    host.xfer(7'h36, 1'b1, 16'hffff, rd);
    rdchk(7'h36, 16'h0000);
    for (int i = 0; i < 5; i++)
      rdchk(7'h37 + 7'(i), v[i]);
    chk("expected_payload", {v[0], v[1], v[2], v[3]}, expected_payload);
    restart = 1'b1;
    cyc(1);
    restart = 1'b0;
    cyc(3);
    chk("expected_payload", {v[0], v[1], v[2], v[3]}, expected_payload);
    rdchk(ADDR_FD_TOLERANCE_CONFIG, v[4]);
    cmp(4'h8, {v[0], v[1], v[2], v[3]}, 1'b1);
    cmp(4'h9, {v[0], v[1], v[2], v[3]}, 1'b0);
    cmp(4'h8, {v[0], v[1], v[2], v[3] ^ 16'h0001}, 1'b0);
    for (int k = 0; k < 10; k++)
    begin
      rl = 4'(xs());
      cmp(rl, {v[0], v[1], v[2], v[3]}, rl == 4'h8);
    end
    cfg_length_code = 4'h2;
    pl = {xs(), 16'(xs()), v[3]};
    cmp(4'h2, pl, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      host.xfer(ADDR_FD_TOLERANCE_CONFIG, 1'b1, 16'(c * 2 + 1), rd);
      chk("glitch_cycles", glitch_exp(c), 64'(dominant_glitch_cycles));
    end
    for (int k = 0; k < 3; k++)
    begin
      host.xfer(ADDR_FD_TOLERANCE_CONFIG, 1'b1, ec[k], rd);
      chk("fd_tolerance_on", 64'(k != 1), 64'(fd_tolerance_on));
      chk("error_counter_active", 64'(k != 0), 64'(error_counter_active));
    end
    host.xfer(ADDR_FD_TOLERANCE_CONFIG, 1'b1, 16'h0021, rd);
    silence_timeout = 1'b1;
    cyc(1);
    silence_timeout = 1'b0;
    cyc(2);
    chk("error_counter_active", 64'(1'b1), 64'(error_counter_active));
    rdchk(ADDR_FD_TOLERANCE_CONFIG, 16'h0001);
    // Silence held across a write that sets the disable bit: the device clear must win at the commit.
    silence_timeout = 1'b1;
    host.xfer(ADDR_FD_TOLERANCE_CONFIG, 1'b1, 16'h0021, rd);
    silence_timeout = 1'b0;
    rdchk(ADDR_FD_TOLERANCE_CONFIG, 16'h0001);
    soft_rst = 1'b1;
    cyc(1);
    soft_rst = 1'b0;
    cyc(3);
    for (int i = 0; i < 5; i++)
      rdchk(7'h37 + 7'(i), 16'h0000);
    chk("expected_payload", 64'h0, expected_payload);
    summarize();
  end
endmodule
